// ===== rtcm_reg_map.sv
`timescale 1ns/10ps
module rtcm_reg_map #(
   parameter logic [1:0] VARIANT  = rtcm_pkg::VAR_WAVE,
   parameter logic [6:0] DEV_ADDR = rtcm_pkg::DEV_ADDR_DEFAULT
) (
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       arst_n_in,
   // serial link pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out_out,
   output logic            sda_oe_n_out,
   // events from the timekeeping core
   input  wire logic       alarm_match_in,
   input  wire logic       watchdog_expire_in,
   input  wire logic       osc_fail_in,
   // strobes to the timekeeping core
   output logic            clock_load_out,
   output logic            watchdog_restart_out,
   // configuration to the timekeeping core
   output logic            oscillator_halt_out,
   output logic [3:0]      wave_rate_select_out,
   output logic            wave_output_enable_out,
   output logic            fixed_kilohertz_output_enable_out,
   output logic [4:0]      alarm_repeat_select_out,
   output logic [2:0]      watchdog_resolution_out,
   output logic [4:0]      watchdog_multiplier_out,
   output logic [1:0]      century_field_out,
   output logic            osc_fail_irq_enable_out,
   output logic            alarm_irq_enable_out,
   output logic            frequency_test_out,
   output logic            output_level_out,
   output logic            trim_sign_out,
   output logic [4:0]      trim_value_out,
   // clock values to load into the counters
   output logic [7:0]      seconds_bcd_out,
   output logic [7:0]      minutes_bcd_out,
   output logic [7:0]      hours_bcd_out,
   output logic [2:0]      weekday_out,
   output logic [7:0]      date_bcd_out,
   output logic [4:0]      month_bcd_out,
   output logic [7:0]      year_bcd_out,
   // alarm compare values
   output logic [4:0]      alarm_month_bcd_out,
   output logic [5:0]      alarm_date_bcd_out,
   output logic [5:0]      alarm_hour_bcd_out,
   output logic [6:0]      alarm_minute_bcd_out,
   output logic [6:0]      alarm_second_bcd_out,
   // status view
   output logic [7:0]      event_status_out
);

   localparam int NREGS = 15;

   // writable-bit mask per offset; zero bits are fixed zeros
   function automatic logic [7:0] wmask(input logic [3:0] a, input logic [1:0] v);
      logic nw;
      nw = (v == rtcm_pkg::VAR_NO_WAVE);
      case (a)
         rtcm_pkg::ADDR_TENTHS:   wmask = 8'h00;
         rtcm_pkg::ADDR_SECONDS:  wmask = 8'hff;
         rtcm_pkg::ADDR_MINUTES:  wmask = nw ? 8'hff : 8'h7f;
         rtcm_pkg::ADDR_HOURS:    wmask = 8'h3f;
         rtcm_pkg::ADDR_WEEKDAY:  wmask = nw ? 8'h07 : 8'hf7;
         rtcm_pkg::ADDR_DATE:     wmask = 8'h3f;
         rtcm_pkg::ADDR_CENTURY:  wmask = 8'hdf;
         rtcm_pkg::ADDR_YEAR:     wmask = 8'hff;
         rtcm_pkg::ADDR_TRIM:     wmask = nw ? 8'hff : 8'h3f;
         rtcm_pkg::ADDR_TIMEOUT:  wmask = 8'hff;
         rtcm_pkg::ADDR_ALARM_MONTH_CTRL: begin
            if (nw) wmask = 8'h9f;
            else if (v == rtcm_pkg::VAR_WAVE_32K) wmask = 8'h7f;
            else wmask = 8'h5f;
         end
         rtcm_pkg::ADDR_ALARM_DATE_REPEAT:  wmask = 8'hff;
         rtcm_pkg::ADDR_ALARM_HOUR_REPEAT:  wmask = 8'hbf;
         rtcm_pkg::ADDR_ALARM_MINUTE_REPEAT:   wmask = 8'hff;
         rtcm_pkg::ADDR_ALARM_SECOND_REPEAT:   wmask = 8'hff;
         default:                 wmask = 8'h00;
      endcase
   endfunction

   // pin synchronisation
   logic [1:0] pins_sync;
   logic       scl_s;
   logic       sda_s;
   logic       scl_p_q;
   logic       sda_p_q;

   rtcm_sync #(
      .WIDTH      (2)
   ) u_sync (
      .ref_clk_in (ref_clk_in),
      .arst_n_in  (arst_n_in),
      .d_in       ({scl_in, sda_in}),
      .q_out      (pins_sync)
   );

   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   // previous synchronised levels for edge finding
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // bus events
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_rise  = scl_s & ~scl_p_q;
   assign scl_fall  = ~scl_s & scl_p_q;
   assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // serial engine state
   rtcm_pkg::rtcm_i2c_state_e state_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic       addr_ph_q;
   logic       rw_q;
   logic       first_q;
   logic       ack_q;
   logic       oe_n_q;

   // register storage
   logic [7:0] regs_q [0:NREGS-1];
   logic [3:0] ptr_q;
   logic       dirty_q;
   logic       clock_load_q;
   logic       wd_restart_q;
   logic [7:0] status;

   // engine decode
   logic       byte_done;
   logic       addr_hit;
   logic       data_rx;
   logic       ptr_load;
   logic       reg_wr;
   logic       rd_take;
   logic       ptr_step;
   logic [7:0] rd_byte;
   logic [7:0] wr_byte;
   logic       clk_wr;
   logic       load_now;
   logic       status_wr;
   logic       status_rd;

   assign byte_done = (state_q == rtcm_pkg::I2C_RX) & scl_fall & (cnt_q == 4'h8);
   assign addr_hit  = (sh_q[7:1] == DEV_ADDR);
   assign data_rx   = byte_done & ~addr_ph_q;
   assign ptr_load  = data_rx & first_q;
   assign reg_wr    = data_rx & ~first_q;
   assign rd_take   = scl_fall & (((state_q == rtcm_pkg::I2C_ACK) & rw_q) |
                                  ((state_q == rtcm_pkg::I2C_RACK) & ack_q));
   assign ptr_step  = reg_wr | rd_take;
   assign rd_byte   = (ptr_q == rtcm_pkg::ADDR_STATUS) ? status : regs_q[ptr_q];
   assign wr_byte   = sh_q & wmask(ptr_q, VARIANT);
   assign clk_wr    = reg_wr & (ptr_q <= rtcm_pkg::ADDR_LAST_CLK);
   assign load_now  = (dirty_q | clk_wr) &
                      (stop_det | (ptr_step & (ptr_q == rtcm_pkg::ADDR_LAST_CLK)));
   assign status_wr = reg_wr & (ptr_q == rtcm_pkg::ADDR_STATUS);
   assign status_rd = rd_take & (ptr_q == rtcm_pkg::ADDR_STATUS);

   // serial byte engine: address, ack, receive and transmit
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q   <= rtcm_pkg::I2C_IDLE;
         cnt_q     <= 4'h0;
         sh_q      <= 8'h00;
         addr_ph_q <= 1'b0;
         rw_q      <= 1'b0;
         first_q   <= 1'b0;
         ack_q     <= 1'b0;
         oe_n_q    <= 1'b1;
      end else if (start_det) begin
         state_q   <= rtcm_pkg::I2C_RX;
         cnt_q     <= 4'h0;
         addr_ph_q <= 1'b1;
         rw_q      <= 1'b0;
         oe_n_q    <= 1'b1;
      end else if (stop_det) begin
         state_q   <= rtcm_pkg::I2C_IDLE;
         oe_n_q    <= 1'b1;
      end else begin
         case (state_q)
            rtcm_pkg::I2C_IDLE: begin
               oe_n_q <= 1'b1;
            end
            rtcm_pkg::I2C_RX: begin
               if (scl_rise) begin
                  sh_q  <= {sh_q[6:0], sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_done) begin
                  if (addr_ph_q && !addr_hit) begin
                     state_q <= rtcm_pkg::I2C_IDLE;   // not our address
                  end else begin
                     state_q <= rtcm_pkg::I2C_ACK;
                     oe_n_q  <= 1'b0;                 // pull low for ack
                     if (addr_ph_q) begin
                        rw_q    <= sh_q[0];
                        first_q <= ~sh_q[0];
                     end else begin
                        first_q <= 1'b0;
                     end
                  end
               end
            end
            rtcm_pkg::I2C_ACK: begin
               if (scl_fall) begin
                  addr_ph_q <= 1'b0;
                  cnt_q     <= 4'h0;
                  if (rw_q) begin
                     state_q <= rtcm_pkg::I2C_TX;
                     sh_q    <= rd_byte;
                     oe_n_q  <= rd_byte[7];
                  end else begin
                     state_q <= rtcm_pkg::I2C_RX;
                     oe_n_q  <= 1'b1;
                  end
               end
            end
            rtcm_pkg::I2C_TX: begin
               if (scl_fall) begin
                  if (cnt_q == 4'h7) begin
                     state_q <= rtcm_pkg::I2C_RACK;
                     cnt_q   <= 4'h0;
                     oe_n_q  <= 1'b1;                 // release for master ack
                  end else begin
                     sh_q   <= {sh_q[6:0], 1'b0};
                     oe_n_q <= sh_q[6];
                     cnt_q  <= cnt_q + 4'h1;
                  end
               end
            end
            rtcm_pkg::I2C_RACK: begin
               if (scl_rise) begin
                  ack_q <= ~sda_s;
               end else if (scl_fall) begin
                  if (ack_q) begin
                     state_q <= rtcm_pkg::I2C_TX;
                     sh_q    <= rd_byte;
                     oe_n_q  <= rd_byte[7];
                  end else begin
                     state_q <= rtcm_pkg::I2C_IDLE;   // master done reading
                  end
               end
            end
            default: begin
               state_q <= rtcm_pkg::I2C_IDLE;
               oe_n_q  <= 1'b1;
            end
         endcase
      end
   end

   // open-drain pin: only ever drives low
   assign sda_out_out  = 1'b0;
   assign sda_oe_n_out = oe_n_q;

   // address pointer wraps after the status byte
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ptr_q <= 4'h0;
      end else if (ptr_load) begin
         ptr_q <= sh_q[3:0];
      end else if (ptr_step) begin
         ptr_q <= ptr_q + 4'h1;
      end
   end

   // register writes; fixed-zero bits are masked off
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < NREGS; i++) begin
            regs_q[i] <= rtcm_pkg::REG_RESET;
         end
      end else begin
         if (reg_wr && (ptr_q != rtcm_pkg::ADDR_STATUS)) begin
            regs_q[ptr_q] <= wr_byte;
         end
         if (clk_wr) begin
            regs_q[rtcm_pkg::ADDR_TENTHS] <= rtcm_pkg::ZERO_BYTE;
         end
      end
   end

   // clock load on pointer passing 07h or stop; watchdog restart on write
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dirty_q      <= 1'b0;
         clock_load_q <= 1'b0;
         wd_restart_q <= 1'b0;
      end else begin
         dirty_q      <= ~load_now & (dirty_q | clk_wr);
         clock_load_q <= load_now;
         wd_restart_q <= reg_wr & (ptr_q == rtcm_pkg::ADDR_TIMEOUT);
      end
   end

   assign clock_load_out       = clock_load_q;
   assign watchdog_restart_out = wd_restart_q;

   // event status flags
   rtcm_flags u_flags (
      .ref_clk_in    (ref_clk_in),
      .arst_n_in     (arst_n_in),
      .alarm_set_in  (alarm_match_in),
      .wd_set_in     (watchdog_expire_in),
      .osc_set_in    (osc_fail_in),
      .read_clear_in (status_rd),
      .write_in      (status_wr),
      .wdata_in      (sh_q),
      .status_out    (status)
   );

   assign event_status_out = status;

   // configuration fields
   assign oscillator_halt_out               = regs_q[rtcm_pkg::ADDR_SECONDS][7];
   assign wave_rate_select_out              = regs_q[rtcm_pkg::ADDR_WEEKDAY][7:4];
   assign wave_output_enable_out            = regs_q[rtcm_pkg::ADDR_ALARM_MONTH_CTRL][6];
   assign fixed_kilohertz_output_enable_out = regs_q[rtcm_pkg::ADDR_ALARM_MONTH_CTRL][5];
   assign alarm_irq_enable_out              = regs_q[rtcm_pkg::ADDR_ALARM_MONTH_CTRL][7];
   assign osc_fail_irq_enable_out           = regs_q[rtcm_pkg::ADDR_MINUTES][7];
   assign century_field_out                 = regs_q[rtcm_pkg::ADDR_CENTURY][7:6];
   assign output_level_out                  = regs_q[rtcm_pkg::ADDR_TRIM][7];
   assign frequency_test_out                = regs_q[rtcm_pkg::ADDR_TRIM][6];
   assign trim_sign_out                     = regs_q[rtcm_pkg::ADDR_TRIM][5];
   assign trim_value_out                    = regs_q[rtcm_pkg::ADDR_TRIM][4:0];

   // repeat bits 5..1 gathered from four registers
   assign alarm_repeat_select_out = {regs_q[rtcm_pkg::ADDR_ALARM_DATE_REPEAT][6],
                                     regs_q[rtcm_pkg::ADDR_ALARM_DATE_REPEAT][7],
                                     regs_q[rtcm_pkg::ADDR_ALARM_HOUR_REPEAT][7],
                                     regs_q[rtcm_pkg::ADDR_ALARM_MINUTE_REPEAT][7],
                                     regs_q[rtcm_pkg::ADDR_ALARM_SECOND_REPEAT][7]};

   // watchdog timeout fields
   assign watchdog_resolution_out = {regs_q[rtcm_pkg::ADDR_TIMEOUT][7],
                                     regs_q[rtcm_pkg::ADDR_TIMEOUT][1:0]};
   assign watchdog_multiplier_out = regs_q[rtcm_pkg::ADDR_TIMEOUT][6:2];

   // bcd clock fields, tens and units nibbles
   assign seconds_bcd_out = {1'b0, regs_q[rtcm_pkg::ADDR_SECONDS][6:0]};
   assign minutes_bcd_out = {1'b0, regs_q[rtcm_pkg::ADDR_MINUTES][6:0]};
   assign hours_bcd_out   = {2'b00, regs_q[rtcm_pkg::ADDR_HOURS][5:0]};
   assign weekday_out     = regs_q[rtcm_pkg::ADDR_WEEKDAY][2:0];
   assign date_bcd_out    = {2'b00, regs_q[rtcm_pkg::ADDR_DATE][5:0]};
   assign month_bcd_out   = regs_q[rtcm_pkg::ADDR_CENTURY][4:0];
   assign year_bcd_out    = regs_q[rtcm_pkg::ADDR_YEAR];

   // bcd alarm fields without the control bits
   assign alarm_month_bcd_out  = regs_q[rtcm_pkg::ADDR_ALARM_MONTH_CTRL][4:0];
   assign alarm_date_bcd_out   = regs_q[rtcm_pkg::ADDR_ALARM_DATE_REPEAT][5:0];
   assign alarm_hour_bcd_out   = regs_q[rtcm_pkg::ADDR_ALARM_HOUR_REPEAT][5:0];
   assign alarm_minute_bcd_out = regs_q[rtcm_pkg::ADDR_ALARM_MINUTE_REPEAT][6:0];
   assign alarm_second_bcd_out = regs_q[rtcm_pkg::ADDR_ALARM_SECOND_REPEAT][6:0];

endmodule // rtcm_reg_map

// ===== rtcm_pkg.sv
// shared constants for the real-time clock register map
package rtcm_pkg;

   // register offsets
   localparam logic [3:0] ADDR_TENTHS   = 4'h0;
   localparam logic [3:0] ADDR_SECONDS  = 4'h1;
   localparam logic [3:0] ADDR_MINUTES  = 4'h2;
   localparam logic [3:0] ADDR_HOURS    = 4'h3;
   localparam logic [3:0] ADDR_WEEKDAY  = 4'h4;
   localparam logic [3:0] ADDR_DATE     = 4'h5;
   localparam logic [3:0] ADDR_CENTURY  = 4'h6;
   localparam logic [3:0] ADDR_YEAR     = 4'h7;
   localparam logic [3:0] ADDR_TRIM     = 4'h8;
   localparam logic [3:0] ADDR_TIMEOUT  = 4'h9;
   localparam logic [3:0] ADDR_ALARM_MONTH_CTRL = 4'ha;
   localparam logic [3:0] ADDR_ALARM_DATE_REPEAT  = 4'hb;
   localparam logic [3:0] ADDR_ALARM_HOUR_REPEAT  = 4'hc;
   localparam logic [3:0] ADDR_ALARM_MINUTE_REPEAT   = 4'hd;
   localparam logic [3:0] ADDR_ALARM_SECOND_REPEAT   = 4'he;
   localparam logic [3:0] ADDR_STATUS   = 4'hf;
   localparam logic [3:0] ADDR_LAST_CLK = 4'h7;

   // event status bit positions
   localparam int WD_FLAG_BIT    = 7;
   localparam int ALARM_FLAG_BIT = 6;
   localparam int OSC_FLAG_BIT   = 2;

   // variants of the map
   localparam logic [1:0] VAR_WAVE       = 2'h0;
   localparam logic [1:0] VAR_WAVE_32K   = 2'h1;
   localparam logic [1:0] VAR_NO_WAVE    = 2'h2;

   // reset values
   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam logic [7:0] ZERO_BYTE      = 8'h00;

   // bus address, value arbitrary
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5a;

   // serial engine states, one-hot
   typedef enum logic [4:0] {
      I2C_IDLE = 5'h01,
      I2C_RX   = 5'h02,
      I2C_ACK  = 5'h04,
      I2C_TX   = 5'h08,
      I2C_RACK = 5'h10
   } rtcm_i2c_state_e;

endpackage : rtcm_pkg

// ===== rtcm_sync.sv
`timescale 1ns/10ps
// two flip-flop synchroniser for pin inputs
module rtcm_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             arst_n_in,
   // data
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // idle bus level is high
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end

   assign q_out = sync_q;

endmodule // rtcm_sync

// ===== rtcm_flags.sv
`timescale 1ns/10ps
// event status byte: hardware sets, read or write clears
module rtcm_flags (
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       arst_n_in,
   // events
   input  wire logic       alarm_set_in,
   input  wire logic       wd_set_in,
   input  wire logic       osc_set_in,
   // host side
   input  wire logic       read_clear_in,
   input  wire logic       write_in,
   input  wire logic [7:0] wdata_in,
   output logic      [7:0] status_out
);

   logic alarm_match_flag_q;
   logic watchdog_expired_flag_q;
   logic oscillator_fail_flag_q;

   // set wins over clear; writes never touch the two read-only flags
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         alarm_match_flag_q      <= 1'b0;
         watchdog_expired_flag_q <= 1'b0;
         oscillator_fail_flag_q  <= 1'b0;
      end else begin
         alarm_match_flag_q      <= alarm_set_in | (alarm_match_flag_q & ~read_clear_in);
         watchdog_expired_flag_q <= wd_set_in | (watchdog_expired_flag_q & ~read_clear_in);
         oscillator_fail_flag_q  <= osc_set_in |
            (oscillator_fail_flag_q & ~(write_in & ~wdata_in[rtcm_pkg::OSC_FLAG_BIT]));
      end
   end

   // remaining positions read zero
   always_comb begin
      status_out                               = rtcm_pkg::ZERO_BYTE;
      status_out[rtcm_pkg::WD_FLAG_BIT]        = watchdog_expired_flag_q;
      status_out[rtcm_pkg::ALARM_FLAG_BIT]     = alarm_match_flag_q;
      status_out[rtcm_pkg::OSC_FLAG_BIT]       = oscillator_fail_flag_q;
   end

endmodule // rtcm_flags

// ===== rtcm_reg_map_assertions.sv
`timescale 1ns/10ps
// pin level checks of the register block
module rtcm_reg_map_chk #(
   parameter logic [1:0] VARIANT = rtcm_pkg::VAR_WAVE
) (
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       arst_n_in,
   // events and pins
   input  wire logic       alarm_match_in,
   input  wire logic       watchdog_expire_in,
   input  wire logic       osc_fail_in,
   input  wire logic       sda_out_out,
   // strobes and variant bits
   input  wire logic       clock_load_out,
   input  wire logic       watchdog_restart_out,
   input  wire logic       fixed_kilohertz_output_enable_out,
   input  wire logic       osc_fail_irq_enable_out,
   input  wire logic       alarm_irq_enable_out,
   input  wire logic [7:0] event_status_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   alarm_flag_set_a: assert property (alarm_match_in |=> event_status_out[6])
      else $error("alarm flag not set");
   alarm_flag_cause_a: assert property ($rose(event_status_out[6]) |-> $past(alarm_match_in))
      else $error("alarm flag set without event");
   wd_flag_set_a: assert property (watchdog_expire_in |=> event_status_out[7])
      else $error("watchdog flag not set");
   wd_flag_cause_a: assert property ($rose(event_status_out[7]) |-> $past(watchdog_expire_in))
      else $error("watchdog flag set without event");
   osc_flag_set_a: assert property (osc_fail_in |=> event_status_out[2])
      else $error("osc fail flag not set");
   osc_flag_cause_a: assert property ($rose(event_status_out[2]) |-> $past(osc_fail_in))
      else $error("osc fail flag set without event");
   status_zeros_a: assert property (event_status_out[5:3] == 3'h0 && event_status_out[1:0] == 2'h0)
      else $error("status fixed bits not zero");
   variant_bits_a: assert property ((VARIANT == rtcm_pkg::VAR_WAVE) |-> !fixed_kilohertz_output_enable_out
      && !osc_fail_irq_enable_out && !alarm_irq_enable_out)
      else $error("absent variant bit set");
   restart_pulse_a: assert property ($rose(watchdog_restart_out) |=> !watchdog_restart_out)
      else $error("restart pulse too long");
   load_pulse_a: assert property ($rose(clock_load_out) |=> !clock_load_out)
      else $error("load pulse too long");
   sda_low_only_a: assert property (sda_out_out == 1'b0)
      else $error("sda drive level not low");
endmodule // rtcm_reg_map_chk

bind rtcm_reg_map rtcm_reg_map_chk #(.VARIANT(VARIANT)) chk (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
   .alarm_match_in(alarm_match_in), .watchdog_expire_in(watchdog_expire_in), .osc_fail_in(osc_fail_in),
   .sda_out_out(sda_out_out), .clock_load_out(clock_load_out), .watchdog_restart_out(watchdog_restart_out),
   .fixed_kilohertz_output_enable_out(fixed_kilohertz_output_enable_out),
   .osc_fail_irq_enable_out(osc_fail_irq_enable_out), .alarm_irq_enable_out(alarm_irq_enable_out),
   .event_status_out(event_status_out));

// ===== rtcm_host_model.sv
`timescale 1ns/10ps
// bus master model, open drain, scl idles high
module rtcm_host_model (
   // clock
   input  wire logic ref_clk_in,
   // bus lines, sda_out high means released
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // wait whole clock cycles
   task automatic w(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   // one bit, 32 ns scl period, sda moves only while scl low
   task automatic bit_x(input logic b, output logic r);
      w(2);
      sda_out <= b;
      w(2);
      scl_out <= 1'b1;
      w(2);
      r = sda_in;
      w(2);
      scl_out <= 1'b0;
   endtask
   // start or repeated start
   task automatic start();
      w(2);
      sda_out <= 1'b1;
      w(2);
      scl_out <= 1'b1;
      w(4);
      sda_out <= 1'b0;
      w(4);
      scl_out <= 1'b0;
   endtask
   task automatic stop();
      w(2);
      sda_out <= 1'b0;
      w(2);
      scl_out <= 1'b1;
      w(4);
      sda_out <= 1'b1;
      w(4);
   endtask
   // eight bits msb first, then the ack bit
   task automatic byte_x(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic a);
      for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
      bit_x(mack, a);
   endtask
   // pointer then data bytes, na collects every nack
   task automatic write_seq(input logic [6:0] dev, input logic [3:0] p, input logic [7:0] d[$], output logic na);
      logic [7:0] rx;
      logic a;
      start();
      byte_x({dev, 1'b0}, 1'b1, rx, na);
      byte_x({4'h0, p}, 1'b1, rx, a);
      na |= a;
      foreach (d[i]) begin
         byte_x(d[i], 1'b1, rx, a);
         na |= a;
      end
      stop();
   endtask
   // single byte read through a repeated start, ends with nack
   task automatic read_reg(input logic [3:0] p, output logic [7:0] d, output logic na);
      logic [7:0] rx;
      logic a;
      start();
      byte_x({rtcm_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rx, na);
      byte_x({4'h0, p}, 1'b1, rx, a);
      na |= a;
      start();
      byte_x({rtcm_pkg::DEV_ADDR_DEFAULT, 1'b1}, 1'b1, rx, a);
      na |= a;
      byte_x(8'hff, 1'b1, d, a);
      stop();
   endtask
endmodule // rtcm_host_model

// ===== tb_top.sv
`timescale 1ns/10ps
// bench for the register map, wave variant
module tb_top;
   logic       ref_clk_in = 1'b0, arst_n_in = 1'b0, alarm_q = 1'b0, wd_q = 1'b0, osc_q = 1'b0;
   logic       scl, sda_m, sda_oe_n, na, wave_en, k32_en, al_irq, osc_irq;
   logic [7:0] rd, status, sec_bcd;
   logic [4:0] rpt, wd_mul, month, tval;
   logic [3:0] rate;
   logic [2:0] wd_res, wday;
   logic [1:0] cent;
   logic       halt, ft, out_lvl, tsign, ld, wdr;
   int         fails = 0, num_checks = 0, loads = 0, rsts = 0;
   // count load and restart pulses
   always @(posedge ref_clk_in) begin
      loads <= loads + int'(ld);
      rsts <= rsts + int'(wdr);
   end
   wire        sda_w = sda_m & sda_oe_n; // pull-up on the shared line
   always #2 ref_clk_in = ~ref_clk_in;
   rtcm_host_model host (.ref_clk_in(ref_clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_m));
   rtcm_reg_map uut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .scl_in(scl), .sda_in(sda_w),
      .sda_out_out(), .sda_oe_n_out(sda_oe_n), .alarm_match_in(alarm_q), .watchdog_expire_in(wd_q),
      .osc_fail_in(osc_q), .clock_load_out(ld), .watchdog_restart_out(wdr), .oscillator_halt_out(halt),
      .wave_rate_select_out(rate), .wave_output_enable_out(wave_en), .fixed_kilohertz_output_enable_out(k32_en),
      .alarm_repeat_select_out(rpt), .watchdog_resolution_out(wd_res), .watchdog_multiplier_out(wd_mul),
      .century_field_out(cent), .osc_fail_irq_enable_out(osc_irq), .alarm_irq_enable_out(al_irq),
      .frequency_test_out(ft), .output_level_out(out_lvl), .trim_sign_out(tsign), .trim_value_out(tval),
      .seconds_bcd_out(sec_bcd), .minutes_bcd_out(), .hours_bcd_out(), .weekday_out(wday), .date_bcd_out(),
      .month_bcd_out(month),
      .year_bcd_out(), .alarm_month_bcd_out(), .alarm_date_bcd_out(), .alarm_hour_bcd_out(),
      .alarm_minute_bcd_out(), .alarm_second_bcd_out(), .event_status_out(status));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (fails == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // one byte write with ack check
   task automatic wr(input logic [3:0] p, input logic [7:0] d);
      host.write_seq(rtcm_pkg::DEV_ADDR_DEFAULT, p, '{d}, na);
      check({7'h0, na}, 8'h00);
   endtask
   // read back and compare
   task automatic rdchk(input logic [3:0] p, input logic [7:0] exp);
      host.read_reg(p, rd, na);
      check({7'h0, na}, 8'h00);
      check(rd, exp);
   endtask
   task automatic t_reset();
      check(status, 8'h00);
      check({7'h0, sda_oe_n}, 8'h01);
      check({wd_res, wd_mul}, 8'h00);
   endtask
   task automatic t_map();
      wr(4'h9, 8'hc5);
      check({5'h0, wd_res}, 8'h05);
      check({3'h0, wd_mul}, 8'h11);
      rdchk(4'h9, 8'hc5);
      check(rsts[7:0], 8'h01);
      wr(4'h8, 8'h2a);
      check({out_lvl, ft, tsign, tval}, 8'h2a);
      wr(4'h6, 8'hf2);
      check({6'h0, cent}, 8'h03);
      check({3'h0, month}, 8'h12);
      rdchk(4'h6, 8'hd2);
      wr(4'h4, 8'hff);
      check({4'h0, rate}, 8'h0f);
      check({5'h0, wday}, 8'h07);
      rdchk(4'h4, 8'hf7);
      wr(4'ha, 8'hff);
      check({5'h0, wave_en, k32_en, al_irq}, 8'h04);
      rdchk(4'ha, 8'h5f);
      wr(4'h2, 8'hd9);
      check({7'h0, osc_irq}, 8'h00);
      rdchk(4'h2, 8'h59);
      check(loads[7:0], 8'h03);
   endtask
   task automatic t_repeat();
      host.write_seq(rtcm_pkg::DEV_ADDR_DEFAULT, 4'hb, '{8'hc1, 8'hc0, 8'h80, 8'h00}, na);
      check({3'h0, rpt}, 8'h1e);
      rdchk(4'hc, 8'h80);
   endtask
   task automatic t_tenths();
      wr(4'h0, 8'h37);
      rdchk(4'h0, 8'h00);
      wr(4'h1, 8'hc5);
      check(sec_bcd, 8'h45);
      check({7'h0, halt}, 8'h01);
      rdchk(4'h0, 8'h00);
      check(loads[7:0], 8'h05);
   endtask
   task automatic t_flags();
      alarm_q <= 1'b1;
      wd_q <= 1'b1;
      osc_q <= 1'b1;
      @(posedge ref_clk_in);
      {alarm_q, wd_q, osc_q} <= 3'h0;
      repeat (2) @(posedge ref_clk_in);
      #1;
      check(status, 8'hc4);
      wr(4'hf, 8'h00);
      check(status, 8'hc0);
      rdchk(4'hf, 8'hc0);
      check(status, 8'h00);
   endtask
   task automatic t_stranger();
      host.write_seq(7'h11, 4'h9, '{8'h00}, na);
      check({7'h0, na}, 8'h01);
      rdchk(4'h9, 8'hc5);
   endtask
   // reset in mid-run clears the map, bus still answers
   task automatic t_rerst();
      arst_n_in <= 1'b0;
      @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      check({wd_res, wd_mul}, 8'h00);
      check({rate, 1'b0, wday}, 8'h00);
      rdchk(4'h9, 8'h00);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      t_reset();
      t_map();
      t_repeat();
      t_tenths();
      t_flags();
      t_stranger();
      t_rerst();
      conclude();
   end
   // hang guard, well beyond the run length
   initial begin
      #200000;
      fails++;
      conclude();
   end
endmodule // tb_top
